// ===== uat_peer.sv
// remote serial peer: decodes the transmit wire and drives the receive wire
// assumes a fixed bit period in system clock cycles and an idle-high wire
`timescale 1ns/1ps
module uat_peer #(
    parameter int BIT_CYC = 4
) (
    input  wire logic       clk,
    input  wire logic       line_i,
    input  wire logic [3:0] nbits,
    output logic            line_o,
    output logic [9:0]      frame,
    output int              nrx
);
    // decode: start on a falling wire, sample every bit after the start bit at its centre, stop bit last
    initial begin
        nrx = 0;
        frame = '0;
        line_o = 1'b1;
        forever begin
            @(negedge line_i);
            frame = '0;
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i <= 32'(nbits); i++) begin
                repeat (BIT_CYC) @(posedge clk);
                frame[i] = line_i;
            end
            nrx++;
        end
    end

    // drive one frame: space start, data low bit first, then the given stop level
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            line_o <= f[k];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk);
        line_o <= 1'b1; // idle mark
    endtask : send
endmodule : uat_peer

// ===== uat_pkg.sv
// constants, register map and carrier types of the asynchronous serial transmitter
// assumes a 32-bit avalon-mm register bus and a single system clock
package uat_pkg;

    // register byte offsets
    localparam logic [4:0]  OFF_CTRL   = 5'h00;
    localparam logic [4:0]  OFF_BAUD   = 5'h04;
    localparam logic [4:0]  OFF_TXDATA = 5'h08;
    localparam logic [4:0]  OFF_STATUS = 5'h0c;
    localparam logic [4:0]  OFF_RXDATA = 5'h10;

    // reset values and writable bits
    localparam logic [31:0] CTRL_RST   = 32'h0000_0800;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_0fff;
    localparam logic [15:0] BAUD_RST   = 16'h0000;

    // character formats
    localparam logic [3:0]  MODE_8N    = 4'h0;
    localparam logic [3:0]  MODE_7N    = 4'h1;
    localparam logic [3:0]  MODE_8O    = 4'h2;
    localparam logic [3:0]  MODE_8E    = 4'h3;
    localparam logic [3:0]  MODE_8A    = 4'h4;
    localparam logic [3:0]  DBITS_7    = 4'h7;
    localparam logic [3:0]  DBITS_8    = 4'h8;

    // stop length codes
    localparam logic [1:0]  STOP_1     = 2'h0;
    localparam logic [1:0]  STOP_1P5   = 2'h1;

    // divisor ticks per bit for normal and high-speed multiplier
    localparam logic [5:0]  TICKS_NORM = 6'h10;
    localparam logic [5:0]  TICKS_HIGH = 6'h04;

    // status and receive data bit positions
    localparam int          ST_RDY     = 0;
    localparam int          ST_EMPTY   = 1;
    localparam int          ST_OVR     = 2;
    localparam int          ST_FERR    = 3;
    localparam int          ST_RXAV    = 4;
    localparam int          RXD_VALID  = 9;

    // control register layout
    typedef struct packed {
        logic [19:0] rsvd;
        logic        pin_direction_control;   // 1 = port leaves pin undriven
        logic        baud_multiplier_select;  // 1 = four ticks per bit
        logic [1:0]  stop_sel;
        logic [3:0]  mode;
        logic        transmit_polarity_invert;
        logic        rx_en;
        logic        transmit_enable_bit;
        logic        on;
    } uat_ctrl_t;

    // one bus request as seen by the slave
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [3:0]  be;
        logic [31:0] wd;
    } uat_req_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uat_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uat_rx_st_t;

endpackage : uat_pkg

// ===== uat_transmitter.sv
// asynchronous serial transmitter with shared framing, baud divisor and receive error checks
// assumes an avalon-mm master on SYS_CLK and a remote serial peer on the pins
//
// What this block does
// - line idles at mark, nrz levels
// - frame is start, data, optional ninth, stops
// - start bit space, stop bits mark
// - start, data and ninth bits last one bit period
// - bit timing from 16-bit divisor
// - data bits go least significant first
// - tx and rx share format and rate
// - five formats: 7, 8, parity, address
// - shift register loads only from buffer
// - busy transmitter forces pin to output
// - idle transmitter leaves pin to port
// - port output direction keeps module driving
// - polarity change moves pin level at once
// - ready flag when enabled and buffer free
// - stop length one, one and a half, two
// - flag overrun when receive buffer full
// - flag framing error on bad stop
// - output to pin and internal signal
// - pending char loads at stop start
// - mode one sends seven low bits
// - modes three/two add even/odd parity
// - empty flag set idle, cleared on load
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module uat_transmitter
    import uat_pkg::*;
#(
    parameter int DIV_W     = 16,
    parameter int RXQ_DEPTH = 2
) (
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        RX_PIN,
    output logic             TX_PIN_O,
    output logic             TX_PIN_OE_N,
    output logic             TX_INTERNAL,
    output logic             TX_READY
);

    localparam int QW = $clog2(RXQ_DEPTH + 1);

    // whole state of the block
    typedef struct packed {
        logic                           wreq;
        logic [31:0]                    rdata;
        uat_ctrl_t                      ctrl;
        logic [DIV_W-1:0]               div;
        logic [8:0]                     hold;
        logic                           hold_full;
        uat_tx_st_t                     tst;
        logic [8:0]                     transmit_shift_register;
        logic [3:0]                     tidx;
        logic [5:0]                     tcnt;
        logic [DIV_W-1:0]               tbcnt;
        logic                           pend;
        logic                           line;
        logic                           pin;
        logic                           pin_int;
        logic                           oe_n;
        logic                           rdy;
        logic                           empty;
        uat_rx_st_t                     rxs;
        logic                           sync1;
        logic                           sync2;
        logic                           rprev;
        logic [8:0]                     rsr;
        logic [3:0]                     ridx;
        logic [5:0]                     rcnt;
        logic [DIV_W-1:0]               rbcnt;
        logic [RXQ_DEPTH-1:0][8:0]      rxq;
        logic [QW-1:0]                  rxn;
        logic                           ovr;
        logic                           ferr;
    } uat_state_t;

    uat_state_t s_r;
    uat_state_t s_nxt;
    uat_req_t   bq;
    logic [5:0] mult;
    logic [5:0] half;
    logic [5:0] stop_ticks;
    logic [3:0] nbits;
    logic       ninth;
    logic       tx_act;
    logic       rx_act;
    logic       ttick;
    logic       rtick;
    logic       bit_end;
    logic       rbit_end;
    logic       acc_w;
    logic       acc_r;
    logic [31:0] bmask;
    logic       go_stop;
    logic       rx_push;
    logic       rx_pop;

    // builds the shift word, ninth bit computed per format
    function automatic logic [8:0] frame_of(input logic [8:0] d, input logic [3:0] m);
        logic [8:0] f;
        f = d;
        case (m)
            MODE_7N: f = {2'h0, d[6:0]};
            MODE_8O: f[8] = ~^d[7:0];
            MODE_8E: f[8] = ^d[7:0];
            MODE_8A: f[8] = d[8];
            default: f[8] = 1'b0;
        endcase
        return f;
    endfunction : frame_of

    // bus request and shared format decode
    assign bq         = {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA};
    assign acc_w      = bq.wr && !s_r.wreq;
    assign acc_r      = bq.rd && !s_r.wreq;
    assign bmask      = {{8{bq.be[3]}}, {8{bq.be[2]}}, {8{bq.be[1]}}, {8{bq.be[0]}}};
    assign mult       = s_r.ctrl.baud_multiplier_select ? TICKS_HIGH : TICKS_NORM;
    assign half       = mult >> 1;
    assign nbits      = (s_r.ctrl.mode == MODE_7N) ? DBITS_7 : DBITS_8;
    assign ninth      = (s_r.ctrl.mode == MODE_8O) || (s_r.ctrl.mode == MODE_8E) || (s_r.ctrl.mode == MODE_8A);
    assign stop_ticks = (s_r.ctrl.stop_sel == STOP_1)   ? mult :
                        (s_r.ctrl.stop_sel == STOP_1P5) ? 6'(mult + half) : 6'(mult << 1);
    assign tx_act     = s_r.ctrl.on && s_r.ctrl.transmit_enable_bit;
    assign rx_act     = s_r.ctrl.on && s_r.ctrl.rx_en;
    assign ttick      = (s_r.tbcnt == s_r.div);
    assign rtick      = (s_r.rbcnt == s_r.div);
    assign bit_end    = ttick && (s_r.tcnt == 6'(mult - 6'h01));
    assign rbit_end   = rtick && (s_r.rcnt == 6'(mult - 6'h01));

    // next-state logic of bus slave, transmitter and receiver
    always_comb begin
        s_nxt   = s_r;
        go_stop = 1'b0;
        rx_push = 1'b0;
        rx_pop  = 1'b0;

        // waitrequest drops for one cycle, one cycle after the request appears
        s_nxt.wreq = !((bq.rd || bq.wr) && s_r.wreq);
        if (bq.rd && s_r.wreq) begin
            s_nxt.rdata = 32'h0;
            case (bq.addr)
                OFF_CTRL:   s_nxt.rdata = 32'(s_r.ctrl);
                OFF_BAUD:   s_nxt.rdata = 32'(s_r.div);
                OFF_STATUS: begin
                    s_nxt.rdata[ST_RDY]   = s_r.rdy;
                    s_nxt.rdata[ST_EMPTY] = s_r.empty;
                    s_nxt.rdata[ST_OVR]   = s_r.ovr;
                    s_nxt.rdata[ST_FERR]  = s_r.ferr;
                    s_nxt.rdata[ST_RXAV]  = (s_r.rxn != '0);
                end
                OFF_RXDATA: begin
                    s_nxt.rdata[8:0]       = s_r.rxq[0];
                    s_nxt.rdata[RXD_VALID] = (s_r.rxn != '0);
                end
                default:    s_nxt.rdata = 32'h0;
            endcase
        end

        // control, divisor and error clear writes
        if (acc_w && bq.addr == OFF_CTRL) begin
            s_nxt.ctrl = uat_ctrl_t'((32'(s_r.ctrl) & ~(bmask & CTRL_WMASK)) | (bq.wd & bmask & CTRL_WMASK));
        end
        if (acc_w && bq.addr == OFF_BAUD) begin
            s_nxt.div = DIV_W'((32'(s_r.div) & ~bmask) | (bq.wd & bmask));
        end
        if (acc_w && bq.addr == OFF_STATUS && bq.be[0]) begin
            if (bq.wd[ST_OVR]) begin
                s_nxt.ovr = 1'b0;
            end
            if (bq.wd[ST_FERR]) begin
                s_nxt.ferr = 1'b0;
            end
        end

        // transmitter: prescaler runs only while a frame is on the line
        s_nxt.tbcnt = (s_r.tst == TX_IDLE || ttick) ? '0 : s_r.tbcnt + DIV_W'(1);
        if (ttick) begin
            s_nxt.tcnt = s_r.tcnt + 6'h01;
        end
        if (!tx_act) begin
            s_nxt.tst  = TX_IDLE;
            s_nxt.pend = 1'b0;
        end else begin
            unique case (s_r.tst)
                TX_IDLE: begin
                    if (s_r.hold_full) begin
                        s_nxt.transmit_shift_register = frame_of(s_r.hold, s_r.ctrl.mode);
                        s_nxt.hold_full = 1'b0;
                        s_nxt.tst       = TX_START;
                        s_nxt.tcnt      = 6'h00;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        s_nxt.tst  = TX_DATA;
                        s_nxt.tidx = 4'h0;
                        s_nxt.tcnt = 6'h00;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        s_nxt.tcnt = 6'h00;
                        if (s_r.tidx == 4'(nbits - 4'h1)) begin
                            if (ninth) begin
                                s_nxt.tst = TX_PAR;
                            end else begin
                                go_stop = 1'b1;
                            end
                        end else begin
                            s_nxt.tidx = s_r.tidx + 4'h1;
                        end
                    end
                end
                TX_PAR: begin
                    if (bit_end) begin
                        s_nxt.tcnt = 6'h00;
                        go_stop    = 1'b1;
                    end
                end
                TX_STOP: begin
                    if (ttick && s_r.tcnt == 6'(stop_ticks - 6'h01)) begin
                        s_nxt.tcnt = 6'h00;
                        s_nxt.tst  = s_r.pend ? TX_START : TX_IDLE;
                        s_nxt.pend = 1'b0;
                    end
                end
            endcase
        end
        // a waiting character moves into the shift register as the stop bit begins
        if (go_stop) begin
            s_nxt.tst = TX_STOP;
            if (s_r.hold_full) begin
                s_nxt.transmit_shift_register = frame_of(s_r.hold, s_r.ctrl.mode);
                s_nxt.hold_full = 1'b0;
                s_nxt.pend      = 1'b1;
            end
        end
        // buffer write after the load, so a same-cycle write is queued
        if (acc_w && bq.addr == OFF_TXDATA && bq.be[0]) begin
            s_nxt.hold      = bq.wd[8:0];
            s_nxt.hold_full = 1'b1;
        end

        // line level from the next state
        unique case (s_nxt.tst)
            TX_IDLE:  s_nxt.line = 1'b1;
            TX_START: s_nxt.line = 1'b0;
            TX_DATA:  s_nxt.line = s_nxt.transmit_shift_register[s_nxt.tidx];
            TX_PAR:   s_nxt.line = s_nxt.transmit_shift_register[8];
            TX_STOP:  s_nxt.line = 1'b1;
        endcase
        s_nxt.pin     = s_nxt.line ^ s_nxt.ctrl.transmit_polarity_invert;
        s_nxt.pin_int = s_nxt.pin;
        // drive when busy, or when the port direction says output
        s_nxt.oe_n    = !((s_nxt.ctrl.transmit_enable_bit && s_nxt.tst != TX_IDLE)
                        || !s_nxt.ctrl.pin_direction_control);
        s_nxt.rdy     = s_nxt.ctrl.transmit_enable_bit && !s_nxt.hold_full;
        s_nxt.empty   = (s_nxt.tst == TX_IDLE);

        // receiver: pin synchroniser, then centre sampling on the shared divisor
        s_nxt.sync1 = RX_PIN;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.rprev = s_r.sync2;
        s_nxt.rbcnt = (s_r.rxs == RX_IDLE || rtick) ? '0 : s_r.rbcnt + DIV_W'(1);
        if (rtick) begin
            s_nxt.rcnt = s_r.rcnt + 6'h01;
        end
        if (!rx_act) begin
            s_nxt.rxs = RX_IDLE;
        end else begin
            unique case (s_r.rxs)
                RX_IDLE: begin
                    if (s_r.rprev && !s_r.sync2) begin
                        s_nxt.rxs  = RX_START;
                        s_nxt.rcnt = 6'h00;
                    end
                end
                RX_START: begin
                    if (rtick && s_r.rcnt == 6'(half - 6'h01)) begin
                        s_nxt.rcnt = 6'h00;
                        s_nxt.ridx = 4'h0;
                        s_nxt.rsr  = 9'h000;
                        s_nxt.rxs  = s_r.sync2 ? RX_IDLE : RX_DATA; // high at centre is a glitch
                    end
                end
                RX_DATA: begin
                    if (rbit_end) begin
                        s_nxt.rcnt           = 6'h00;
                        s_nxt.rsr[s_r.ridx]  = s_r.sync2;
                        s_nxt.ridx           = s_r.ridx + 4'h1;
                        if (s_r.ridx == 4'(nbits - 4'h1)) begin
                            s_nxt.rxs = ninth ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rbit_end) begin
                        s_nxt.rcnt   = 6'h00;
                        s_nxt.rsr[8] = s_r.sync2;
                        s_nxt.rxs    = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rbit_end) begin
                        s_nxt.rxs = RX_IDLE;
                        rx_push   = 1'b1;
                        if (!s_r.sync2) begin
                            s_nxt.ferr = 1'b1;
                        end
                    end
                end
            endcase
        end

        // receive queue: pop on an accepted data read, then push
        if (acc_r && bq.addr == OFF_RXDATA && s_r.rxn != '0) begin
            rx_pop = 1'b1;
            for (int i = 0; i < RXQ_DEPTH - 1; i++) begin
                s_nxt.rxq[i] = s_r.rxq[i+1];
            end
            s_nxt.rxn = s_r.rxn - QW'(1);
        end
        if (rx_push) begin
            if (s_nxt.rxn == QW'(RXQ_DEPTH)) begin
                s_nxt.ovr = 1'b1;
            end else begin
                s_nxt.rxq[s_nxt.rxn] = s_nxt.rsr;
                s_nxt.rxn            = s_nxt.rxn + QW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_r         <= '0;
            s_r.wreq    <= 1'b1;
            s_r.ctrl    <= uat_ctrl_t'(CTRL_RST);
            s_r.div     <= DIV_W'(BAUD_RST);
            s_r.line    <= 1'b1;
            s_r.pin     <= 1'b1;
            s_r.pin_int <= 1'b1;
            s_r.oe_n    <= 1'b1;
            s_r.empty   <= 1'b1;
            s_r.sync1   <= 1'b1;
            s_r.sync2   <= 1'b1;
            s_r.rprev   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign AVS_READDATA    = s_r.rdata;
    assign AVS_WAITREQUEST = s_r.wreq;
    assign TX_PIN_O        = s_r.pin;
    assign TX_PIN_OE_N     = s_r.oe_n;
    assign TX_INTERNAL     = s_r.pin_int;
    assign TX_READY        = s_r.rdy;

    // helper: cycles spent in the start bit
    logic [23:0] hc_r;
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hc_r <= 24'h0;
        end else begin
            hc_r <= (s_r.tst == TX_START) ? hc_r + 24'h1 : 24'h0;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_idle_mark: assert property (s_r.tst == TX_IDLE |-> s_r.line) else $error("line not mark in idle");
    a_start_space: assert property (s_r.tst == TX_START |-> !s_r.line) else $error("start bit not space");
    a_stop_mark: assert property (s_r.tst == TX_STOP |-> s_r.line) else $error("stop bit not mark");
    a_start_period: assert property (s_r.tst == TX_START && s_nxt.tst != TX_START && tx_act
        |-> hc_r == 24'(((24'(s_r.div) + 24'h1) * 24'(mult)) - 24'h1)) else $error("start bit length wrong");
    a_lsb_first: assert property (s_r.tst == TX_START && s_nxt.tst == TX_DATA
        |=> s_r.line == s_r.transmit_shift_register[0]) else $error("first data bit not lsb");
    a_seven_bits: assert property (s_r.tst == TX_DATA && s_r.ctrl.mode == MODE_7N
        |-> s_r.tidx < DBITS_7) else $error("eighth bit sent in 7-bit mode");
    a_even_parity: assert property (s_r.tst == TX_PAR && s_r.ctrl.mode == MODE_8E
        |-> s_r.line == ^s_r.transmit_shift_register[7:0]) else $error("even parity wrong");
    a_load_empty: assert property (s_r.tst == TX_IDLE && s_r.hold_full && tx_act
        |=> !s_r.empty && s_r.tst == TX_START) else $error("load did not clear empty");
    a_ready_flag: assert property (s_r.rdy == (s_r.ctrl.transmit_enable_bit && !s_r.hold_full))
        else $error("ready flag wrong");
    a_drive_busy: assert property (s_r.ctrl.transmit_enable_bit && s_r.tst != TX_IDLE |-> !TX_PIN_OE_N)
        else $error("busy pin not driven");
    a_pol_follow: assert property ($changed(s_r.ctrl.transmit_polarity_invert) && s_r.tst == TX_IDLE
        |-> TX_PIN_O != s_r.ctrl.transmit_polarity_invert) else $error("polarity not applied");
    a_overrun_flag: assert property (rx_push && s_r.rxn == QW'(RXQ_DEPTH) && !rx_pop |=> s_r.ovr)
        else $error("overrun not flagged");
    a_framing_flag: assert property (rx_act && s_r.rxs == RX_STOP && rbit_end && !s_r.sync2 |=> s_r.ferr)
        else $error("framing error not flagged");

    c_frame_done: cover property (s_r.tst == TX_STOP ##1 s_r.tst == TX_IDLE);
    c_back_to_back: cover property (s_r.tst == TX_STOP && s_r.pend ##1 s_r.tst == TX_START);
    c_parity_frame: cover property (s_r.tst == TX_PAR && s_r.ctrl.mode == MODE_8O);
    c_overrun: cover property (!s_r.ovr ##1 s_r.ovr);

endmodule : uat_transmitter

// ===== uat_transmitter_tb.sv
// self-checking bench for the asynchronous serial transmitter
// assumes the peer model uat_peer and a 100 MHz system clock
`timescale 1ns/1ps
module uat_transmitter_tb;
    import uat_pkg::*;
    typedef struct packed {logic [3:0] mode; logic [3:0] nb; logic [8:0] wd; logic [9:0] fr;} uat_row_t;
    logic        SYS_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [4:0]  AVS_ADDRESS = '0;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = '0;
    logic [31:0] AVS_READDATA, q;
    logic        AVS_WAITREQUEST, TX_PIN_O, TX_PIN_OE_N, TX_INTERNAL, TX_READY, rx_line, tx_wire;
    logic [9:0]  frame;
    logic [3:0]  nbits = 4'h8;
    int          nrx, n0, cyc = 0, num_errors = 0, checks = 0;
    // one row per format: mode, bits decoded, written char, expected bits incl. stop
    uat_row_t    rows [5] = '{'{MODE_8N, 4'h8, 9'h0a5, 10'h1a5}, '{MODE_7N, 4'h7, 9'h02a, 10'h0aa},
                              '{MODE_8O, 4'h9, 9'h007, 10'h207}, '{MODE_8E, 4'h9, 9'h007, 10'h307},
                              '{MODE_8A, 4'h9, 9'h1a5, 10'h3a5}};

    uat_transmitter u_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .RX_PIN(rx_line), .TX_PIN_O(TX_PIN_O), .TX_PIN_OE_N(TX_PIN_OE_N),
        .TX_INTERNAL(TX_INTERNAL), .TX_READY(TX_READY));
    uat_peer u_peer (.clk(SYS_CLK), .line_i(tx_wire), .nbits(nbits), .line_o(rx_line),
        .frame(frame), .nrx(nrx));

    // pin with pull-up: released pin reads high
    assign tx_wire = TX_PIN_OE_N ? 1'b1 : TX_PIN_O;

    // clock and hang guard
    always #5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end

    // control word: pin released, four ticks per bit, one stop, rx and tx on
    function automatic logic [31:0] ctl(input logic [3:0] m, input logic p);
        return {20'h0, 2'h3, 2'h0, m, p, 3'h7};
    endfunction : ctl

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge SYS_CLK);
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
        r = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask : bus

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // main sequence: reset, format rows, back-to-back, receive errors, frame length, polarity
    initial begin
        repeat (3) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        chk(32'(TX_PIN_O), 1, "idle level");
        bus(0, OFF_CTRL, 0, q);
        chk(q, CTRL_RST, "ctrl reset");
        bus(0, 5'h14, 0, q);
        chk(q, 0, "unmapped");
        $display("reset test done");
        foreach (rows[r]) begin
            nbits <= rows[r].nb;
            bus(1, OFF_CTRL, ctl(rows[r].mode, 1'b0), q);
            repeat (2) @(posedge SYS_CLK);
            chk(32'(TX_READY), 1, "ready");
            chk(32'(TX_PIN_OE_N), 1, "released");
            n0 = nrx;
            bus(1, OFF_TXDATA, 32'(rows[r].wd), q);
            repeat (3) @(posedge SYS_CLK);
            chk(32'(TX_PIN_OE_N), 0, "driven");
            chk(32'(TX_INTERNAL), 32'(TX_PIN_O), "internal");
            while (nrx == n0) @(posedge SYS_CLK);
            chk(32'(frame), 32'(rows[r].fr), "frame");
            repeat (8) @(posedge SYS_CLK);
            $display("format row %0d done", r);
        end
        bus(1, OFF_CTRL, ctl(MODE_8N, 1'b0), q);
        nbits <= 4'h8;
        n0 = nrx;
        bus(1, OFF_TXDATA, 32'h0c3, q);
        bus(1, OFF_TXDATA, 32'h03c, q);
        bus(0, OFF_STATUS, 0, q);
        chk(32'(q[ST_EMPTY]), 0, "shift busy");
        chk(32'(TX_READY), 0, "held char");
        while (nrx < n0 + 2) @(posedge SYS_CLK);
        chk(32'(frame), 32'h13c, "second frame");
        repeat (8) @(posedge SYS_CLK);
        bus(0, OFF_STATUS, 0, q);
        chk(32'(q[ST_EMPTY]), 1, "shift empty");
        $display("back-to-back test done");
        for (int k = 1; k <= 3; k++) u_peer.send(8'(k * 17), 1'b1);
        repeat (8) @(posedge SYS_CLK);
        bus(0, OFF_STATUS, 0, q);
        chk(32'(q[ST_OVR]), 1, "overrun");
        bus(0, OFF_RXDATA, 0, q);
        chk(q, 32'h211, "oldest char");
        u_peer.send(8'h44, 1'b0);
        repeat (8) @(posedge SYS_CLK);
        bus(0, OFF_STATUS, 0, q);
        chk(32'(q[ST_FERR]), 1, "framing");
        $display("receive error test done");
        // divisor 1, one and a half stops: nine bits of 8 cycles plus 12 cycles of stop
        bus(1, OFF_BAUD, 1, q);
        bus(0, OFF_BAUD, 0, q);
        chk(q, 1, "divisor");
        bus(1, OFF_CTRL, ctl(MODE_8N, 1'b0) | 32'h100, q);
        bus(1, OFF_TXDATA, 32'h055, q);
        while (TX_PIN_OE_N !== 1'b0) @(posedge SYS_CLK);
        n0 = 0;
        while (TX_PIN_OE_N === 1'b0) begin
            n0++;
            @(posedge SYS_CLK);
        end
        chk(n0, 84, "frame length");
        $display("frame length test done");
        // invert with the block switched off and the port set to output
        bus(1, OFF_CTRL, ctl(MODE_8N, 1'b1) & ~32'h801, q);
        repeat (2) @(posedge SYS_CLK);
        chk(32'(TX_PIN_O), 0, "inverted idle");
        chk(32'(TX_PIN_OE_N), 0, "port output");
        $display("polarity test done");
        end_sim();
    end
endmodule : uat_transmitter_tb
